// [fip_pkg.sv]
// Constants, field layout and types of the frequency input pretreatment block
package fip_pkg;

  // Channel count and clock rate
  localparam int NUM_CH        = 2;
  localparam int CLK_PERIOD_NS = 50;

  // Filter stability times in ns and their cycle counts (rounded up)
  localparam int FILT_LOW_NS  = 4000;
  localparam int FILT_MED_NS  = 40000;
  localparam int FILT_HIGH_NS = 400000;
  localparam int FILT_LOW_CYC =
    (FILT_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FILT_MED_CYC =
    (FILT_MED_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FILT_HIGH_CYC =
    (FILT_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FCNT_W = 14;

  // Filter levels
  typedef enum logic [1:0] {
    FIP_FLT_BYPASS = 2'b00,
    FIP_FLT_LOW    = 2'b01,
    FIP_FLT_MED    = 2'b10,
    FIP_FLT_HIGH   = 2'b11
  } fip_flt_t;

  // Bus slave states
  typedef enum logic [0:0] {
    FIP_WB_IDLE = 1'b0,
    FIP_WB_ACK  = 1'b1
  } fip_wb_t;

  // Scaling factor width and limit
  localparam int          SCALE_W   = 11;
  localparam logic [10:0] SCALE_MAX = 11'h400;
  localparam int          PCNT_W    = 16;

  // Register byte offsets
  localparam logic [7:0] FIP_CFG_OFS    = 8'h00;
  localparam logic [7:0] FIP_CFG_STRIDE = 8'h04;
  localparam logic [7:0] FIP_STAT_OFS   = 8'h10;
  localparam logic [7:0] FIP_ISTAT_OFS  = 8'h14;
  localparam logic [7:0] FIP_IMASK_OFS  = 8'h18;
  localparam logic [7:0] FIP_PCNT_OFS   = 8'h20;

  // Configuration word fields
  localparam int CFG_FLT_LSB  = 0;
  localparam int CFG_SRC_BIT  = 2;
  localparam int CFG_THR_BIT  = 3;
  localparam int CFG_LINE_BIT = 4;
  localparam int CFG_SCL_LSB  = 16;

  // Reset values
  localparam logic [31:0] CFG_RST   = 32'h0001_0001;
  localparam logic [31:0] IMASK_RST = 32'h0000_0000;

  // Status and interrupt field positions
  localparam int STAT_FILT_LSB  = 0;
  localparam int STAT_VALID_LSB = 8;
  localparam int STAT_FAULT_LSB = 16;
  localparam int IRQ_PULSE_LSB  = 0;
  localparam int IRQ_FAULT_LSB  = NUM_CH;
  localparam int IRQ_W          = 2 * NUM_CH;

endpackage

// [fip_ch_if.sv]
// Per-channel carrier between the top, the debounce filter and the prescaler
`timescale 1ns/1ps
interface fip_ch_if;
  import fip_pkg::*;
  logic               raw;
  fip_flt_t           level;
  logic               filt;
  logic [SCALE_W-1:0] scale_n;
  logic               div_pulse;

  modport flt (input raw, input level, output filt);
  modport psc (input filt, input scale_n, output div_pulse);
  modport top (output raw, output level, output scale_n,
               input filt, input div_pulse);
endinterface

// [fip_debounce.sv]
// Debounce filter: passes a transition only after the input stays stable
`timescale 1ns/1ps
module fip_debounce
  import fip_pkg::*;
#(
  parameter logic [FCNT_W-1:0] HIGH_CYC = FCNT_W'(FILT_HIGH_CYC)
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  fip_ch_if.flt     ch
);
  import fip_pkg::*;

  logic [FCNT_W-1:0] cnt_q;
  logic [FCNT_W-1:0] limit;
  logic              filt_q;

  // Stability time for the selected level
  always_comb begin
    case (ch.level)
      FIP_FLT_LOW:  limit = FCNT_W'(FILT_LOW_CYC);
      FIP_FLT_MED:  limit = FCNT_W'(FILT_MED_CYC);
      FIP_FLT_HIGH: limit = HIGH_CYC;
      default:      limit = FCNT_W'(1);
    endcase
  end

  // Hold back each change until stable for the whole limit
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q  <= '0;
      filt_q <= 1'b0;
    end else if (ch.level == FIP_FLT_BYPASS) begin
      filt_q <= ch.raw;
      cnt_q  <= '0;
    end else if (ch.raw == filt_q) begin
      cnt_q  <= '0;
    end else if (cnt_q >= limit - FCNT_W'(1)) begin
      filt_q <= ch.raw;
      cnt_q  <= '0;
    end else begin
      cnt_q  <= cnt_q + FCNT_W'(1);
    end
  end

  assign ch.filt = filt_q;

endmodule

// [fip_prescaler.sv]
// Divide-by-N prescaler on rising edges of the filtered signal
`timescale 1ns/1ps
module fip_prescaler
  import fip_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic rst_i,
  fip_ch_if.psc     ch
);
  import fip_pkg::*;

  logic               prev_q;
  logic               pulse_q;
  logic [SCALE_W-1:0] cnt_q;
  logic               rise;

  assign rise = ch.filt & ~prev_q;

  // Count filtered edges; one output pulse per group of N
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prev_q  <= 1'b0;
      pulse_q <= 1'b0;
      cnt_q   <= '0;
    end else begin
      prev_q  <= ch.filt;
      pulse_q <= 1'b0;
      if (rise) begin
        if (ch.scale_n <= SCALE_W'(1)) begin
          pulse_q <= 1'b1;
          cnt_q   <= '0;
        end else if (cnt_q >= ch.scale_n - SCALE_W'(1)) begin
          pulse_q <= 1'b1;
          cnt_q   <= '0;
        end else begin
          cnt_q   <= cnt_q + SCALE_W'(1);
        end
      end
    end
  end

  assign ch.div_pulse = pulse_q;

endmodule

// [fip_top.sv]
// Frequency input pretreatment: sensor select, debounce, scaling, line check
//
// Overview of operation
// - One sensor per channel, magnetic or active
// - Four selectable debounce levels on every input
// - Bypass level passes one microsecond pulses
// - Low level rejects pulses under 4 us
// - Medium level rejects pulses under 40 us
// - High level rejects pulses under 400 us
// - Output changes only after stable filter time
// - Filter level resets to low
// - Divide pulse train by scaling factor
// - Scaling factor one bypasses the divider
// - Factor N gives one pulse per N
// - Threshold select picks sensitive or noisy level
// - Wrong magnetic connection clears validity flag
// - Enabled line check reports broken wire fault
//
// The implementer's own choices: the address map and the Wishbone interface to the registers.
`timescale 1ns/1ps
module fip_top
  import fip_pkg::*;
#(
  parameter int HIGH_FILT_CYC = FILT_HIGH_CYC
) (
  input  wire logic              CLK_SYS_I,
  input  wire logic              SYS_RST_I,
  input  wire logic              WB_CYC_I,
  input  wire logic              WB_STB_I,
  input  wire logic              WB_WE_I,
  input  wire logic [7:0]        WB_ADR_I,
  input  wire logic [3:0]        WB_SEL_I,
  input  wire logic [31:0]       WB_DAT_I,
  output logic      [31:0]       WB_DAT_O,
  output logic                   WB_ACK_O,
  input  wire logic [NUM_CH-1:0] MAGNETIC_PICKUP_INPUT_I,
  input  wire logic [NUM_CH-1:0] ACTIVE_PICKUP_INPUT_I,
  input  wire logic [NUM_CH-1:0] MAG_LINE_OK_I,
  output logic      [NUM_CH-1:0] SCALED_PULSE_O,
  output logic      [NUM_CH-1:0] FREQUENCY_VALID_FLAG_O,
  output logic      [NUM_CH-1:0] WIRE_FAULT_O,
  output logic      [NUM_CH-1:0] PICKUP_THRESHOLD_SELECT_O,
  output logic                   IRQ_O
);
  import fip_pkg::*;

  // Input synchronisers, two stages each
  logic [NUM_CH-1:0] mag_s1_q;
  logic [NUM_CH-1:0] mag_s2_q;
  logic [NUM_CH-1:0] act_s1_q;
  logic [NUM_CH-1:0] act_s2_q;
  logic [NUM_CH-1:0] line_s1_q;
  logic [NUM_CH-1:0] line_s2_q;

  always_ff @(posedge CLK_SYS_I) begin
    if (SYS_RST_I) begin
      mag_s1_q  <= '0;
      mag_s2_q  <= '0;
      act_s1_q  <= '0;
      act_s2_q  <= '0;
      line_s1_q <= '0;
      line_s2_q <= '0;
    end else begin
      mag_s1_q  <= MAGNETIC_PICKUP_INPUT_I;
      mag_s2_q  <= mag_s1_q;
      act_s1_q  <= ACTIVE_PICKUP_INPUT_I;
      act_s2_q  <= act_s1_q;
      line_s1_q <= MAG_LINE_OK_I;
      line_s2_q <= line_s1_q;
    end
  end

  // Bus slave state
  fip_wb_t     wb_state_q;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic [31:0] wmask;
  logic        wr_stb;

  assign wmask = {{8{WB_SEL_I[3]}}, {8{WB_SEL_I[2]}},
                  {8{WB_SEL_I[1]}}, {8{WB_SEL_I[0]}}};
  assign wr_stb = (wb_state_q == FIP_WB_ACK) & WB_CYC_I & WB_STB_I
                  & WB_WE_I;

  // Per-channel configuration and state
  fip_flt_t           flt_q   [NUM_CH];
  logic [SCALE_W-1:0] scale_q [NUM_CH];
  logic [PCNT_W-1:0]  pcnt_q  [NUM_CH];
  logic [31:0]        cfg_rd  [NUM_CH];
  logic [NUM_CH-1:0]  src_act_q;
  logic [NUM_CH-1:0]  thr_q;
  logic [NUM_CH-1:0]  line_en_q;
  logic [NUM_CH-1:0]  filt_lvl;
  logic [NUM_CH-1:0]  div_pulse;
  logic [NUM_CH-1:0]  valid_q;
  logic [NUM_CH-1:0]  fault_q;
  logic [NUM_CH-1:0]  fault_d;
  logic [NUM_CH-1:0]  fault_rise;

  genvar i;
  generate
    for (i = 0; i < NUM_CH; i++) begin : g_ch
      fip_ch_if    chif ();
      logic [31:0] cfg_new;
      logic [7:0]  cfg_adr;

      assign cfg_adr = FIP_CFG_OFS + 8'(i * int'(FIP_CFG_STRIDE));

      // Readback of the configuration word
      always_comb begin
        cfg_rd[i] = '0;
        cfg_rd[i][CFG_FLT_LSB +: 2] = flt_q[i];
        cfg_rd[i][CFG_SRC_BIT] = src_act_q[i];
        cfg_rd[i][CFG_THR_BIT] = thr_q[i];
        cfg_rd[i][CFG_LINE_BIT] = line_en_q[i];
        cfg_rd[i][CFG_SCL_LSB +: SCALE_W] = scale_q[i];
      end

      assign cfg_new = (cfg_rd[i] & ~wmask) | (WB_DAT_I & wmask);

      // Configuration register write, byte lanes honoured
      always_ff @(posedge CLK_SYS_I) begin
        if (SYS_RST_I) begin
          flt_q[i]     <= fip_flt_t'(CFG_RST[CFG_FLT_LSB +: 2]);
          src_act_q[i] <= CFG_RST[CFG_SRC_BIT];
          thr_q[i]     <= CFG_RST[CFG_THR_BIT];
          line_en_q[i] <= CFG_RST[CFG_LINE_BIT];
          scale_q[i]   <= CFG_RST[CFG_SCL_LSB +: SCALE_W];
        end else if (wr_stb && WB_ADR_I == cfg_adr) begin
          flt_q[i]     <= fip_flt_t'(cfg_new[CFG_FLT_LSB +: 2]);
          src_act_q[i] <= cfg_new[CFG_SRC_BIT];
          thr_q[i]     <= cfg_new[CFG_THR_BIT];
          line_en_q[i] <= cfg_new[CFG_LINE_BIT];
          if (cfg_new[CFG_SCL_LSB +: SCALE_W] > SCALE_MAX) begin
            scale_q[i] <= SCALE_MAX;
          end else begin
            scale_q[i] <= cfg_new[CFG_SCL_LSB +: SCALE_W];
          end
        end
      end

      // One sensor feeds the channel, chosen by the source bit
      assign chif.raw = src_act_q[i] ? act_s2_q[i] : mag_s2_q[i];
      assign chif.level   = flt_q[i];
      assign chif.scale_n = scale_q[i];
      assign filt_lvl[i]  = chif.filt;
      assign div_pulse[i] = chif.div_pulse;

      // Filter first, then divider
      fip_debounce #(
        .HIGH_CYC (FCNT_W'(HIGH_FILT_CYC))
      ) u_flt (
        .clk_i (CLK_SYS_I),
        .rst_i (SYS_RST_I),
        .ch    (chif.flt)
      );

      fip_prescaler u_psc (
        .clk_i (CLK_SYS_I),
        .rst_i (SYS_RST_I),
        .ch    (chif.psc)
      );

      // Count of divided pulses, wraps
      always_ff @(posedge CLK_SYS_I) begin
        if (SYS_RST_I) begin
          pcnt_q[i] <= '0;
        end else if (div_pulse[i]) begin
          pcnt_q[i] <= pcnt_q[i] + PCNT_W'(1);
        end
      end

      // Broken wire only when checking a magnetic channel
      assign fault_d[i] = line_en_q[i] & ~src_act_q[i]
                          & ~line_s2_q[i];
    end
  endgenerate

  // Validity and fault levels
  always_ff @(posedge CLK_SYS_I) begin
    if (SYS_RST_I) begin
      valid_q <= '0;
      fault_q <= '0;
    end else begin
      valid_q <= src_act_q | line_s2_q;
      fault_q <= fault_d;
    end
  end

  assign fault_rise = fault_d & ~fault_q;

  // Interrupt status, mask and output
  logic [IRQ_W-1:0] istat_q;
  logic [IRQ_W-1:0] imask_q;
  logic [IRQ_W-1:0] w1c;
  logic [IRQ_W-1:0] ev;
  logic             irq_q;

  assign ev  = {fault_rise, div_pulse};
  assign w1c = (wr_stb && WB_ADR_I == FIP_ISTAT_OFS)
               ? (WB_DAT_I[IRQ_W-1:0] & wmask[IRQ_W-1:0]) : '0;

  // Sticky events; a new event wins over a clear
  always_ff @(posedge CLK_SYS_I) begin
    if (SYS_RST_I) begin
      istat_q <= '0;
    end else begin
      istat_q <= (istat_q & ~w1c) | ev;
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (SYS_RST_I) begin
      imask_q <= IMASK_RST[IRQ_W-1:0];
    end else if (wr_stb && WB_ADR_I == FIP_IMASK_OFS) begin
      imask_q <= (imask_q & ~wmask[IRQ_W-1:0])
                 | (WB_DAT_I[IRQ_W-1:0] & wmask[IRQ_W-1:0]);
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (SYS_RST_I) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(istat_q & imask_q);
    end
  end

  // Read multiplexer, unmapped reads as zero
  always_comb begin
    rdata_d = '0;
    case (WB_ADR_I)
      FIP_STAT_OFS: begin
        rdata_d[STAT_FILT_LSB +: NUM_CH]  = filt_lvl;
        rdata_d[STAT_VALID_LSB +: NUM_CH] = valid_q;
        rdata_d[STAT_FAULT_LSB +: NUM_CH] = fault_q;
      end
      FIP_ISTAT_OFS: rdata_d[IRQ_W-1:0] = istat_q;
      FIP_IMASK_OFS: rdata_d[IRQ_W-1:0] = imask_q;
      default: begin
        for (int k = 0; k < NUM_CH; k++) begin
          if (WB_ADR_I == FIP_CFG_OFS + 8'(k * int'(FIP_CFG_STRIDE))) begin
            rdata_d = cfg_rd[k];
          end
          if (WB_ADR_I == FIP_PCNT_OFS + 8'(k * int'(FIP_CFG_STRIDE))) begin
            rdata_d[PCNT_W-1:0] = pcnt_q[k];
          end
        end
      end
    endcase
  end

  // Wishbone classic slave: ack one cycle after the request
  always_ff @(posedge CLK_SYS_I) begin
    if (SYS_RST_I) begin
      wb_state_q <= FIP_WB_IDLE;
      rdata_q    <= '0;
    end else begin
      case (wb_state_q)
        FIP_WB_IDLE: begin
          if (WB_CYC_I && WB_STB_I) begin
            wb_state_q <= FIP_WB_ACK;
            rdata_q    <= rdata_d;
          end
        end
        FIP_WB_ACK: wb_state_q <= FIP_WB_IDLE;
        default:    wb_state_q <= FIP_WB_IDLE;
      endcase
    end
  end

  assign WB_ACK_O = (wb_state_q == FIP_WB_ACK) & WB_CYC_I & WB_STB_I;
  assign WB_DAT_O = rdata_q;

  // Pin-side outputs
  assign SCALED_PULSE_O            = div_pulse;
  assign FREQUENCY_VALID_FLAG_O    = valid_q;
  assign WIRE_FAULT_O              = fault_q;
  assign PICKUP_THRESHOLD_SELECT_O = thr_q;
  assign IRQ_O                     = irq_q;

endmodule

// [fip_top_asserts.sv]
// Port checks for the frequency input pretreatment top
`timescale 1ns/1ps
module fip_top_asserts
  import fip_pkg::*;
#(
  parameter int HIGH_FILT_CYC = FILT_HIGH_CYC
) (
  input wire logic              CLK_SYS_I,
  input wire logic              SYS_RST_I,
  input wire logic              WB_CYC_I,
  input wire logic              WB_STB_I,
  input wire logic [31:0]       WB_DAT_O,
  input wire logic              WB_ACK_O,
  input wire logic [NUM_CH-1:0] MAGNETIC_PICKUP_INPUT_I,
  input wire logic [NUM_CH-1:0] ACTIVE_PICKUP_INPUT_I,
  input wire logic [NUM_CH-1:0] MAG_LINE_OK_I,
  input wire logic [NUM_CH-1:0] SCALED_PULSE_O,
  input wire logic [NUM_CH-1:0] FREQUENCY_VALID_FLAG_O,
  input wire logic [NUM_CH-1:0] WIRE_FAULT_O,
  input wire logic [NUM_CH-1:0] PICKUP_THRESHOLD_SELECT_O,
  input wire logic              IRQ_O
);
  default clocking cb @(posedge CLK_SYS_I);
  endclocking
  default disable iff (SYS_RST_I);

  // Either pin of a channel, seen four cycles ahead of its pulse
  logic [NUM_CH-1:0] pin_any;
  assign pin_any = MAGNETIC_PICKUP_INPUT_I | ACTIVE_PICKUP_INPUT_I;

  // Bus handshake
  ack_follows_req_a: assert property ($rose(WB_CYC_I && WB_STB_I)
    |=> WB_ACK_O) else $error("ack missing after request");
  ack_single_a: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack longer than one cycle");
  ack_needs_req_a: assert property (WB_ACK_O |-> WB_CYC_I && WB_STB_I)
    else $error("ack without request");
  rdata_hold_a: assert property (!(WB_CYC_I && WB_STB_I)
    |=> $stable(WB_DAT_O)) else $error("read data moved while idle");
  // Pulse path
  pulse_single_a: assert property (SCALED_PULSE_O[0]
    |=> !SCALED_PULSE_O[0]) else $error("scaled pulse too long");
  pulse_cause_a: assert property (SCALED_PULSE_O[1]
    |-> $past(pin_any[1], 4)) else $error("pulse without input");
  // Line check
  fault_no_valid_a: assert property (WIRE_FAULT_O[1]
    |-> !FREQUENCY_VALID_FLAG_O[1]) else $error("valid during fault");
  fault_cause_a: assert property ($rose(WIRE_FAULT_O[1])
    |-> !$past(MAG_LINE_OK_I[1], 3)) else $error("fault with good line");
  reset_quiet_a: assert property ($fell(SYS_RST_I)
    |-> SCALED_PULSE_O == '0 && WIRE_FAULT_O == '0 && !IRQ_O
        && PICKUP_THRESHOLD_SELECT_O == '0) else $error("reset state");
endmodule

bind fip_top fip_top_asserts #(.HIGH_FILT_CYC(HIGH_FILT_CYC)) u_chk (
  .CLK_SYS_I(CLK_SYS_I), .SYS_RST_I(SYS_RST_I), .WB_CYC_I(WB_CYC_I),
  .WB_STB_I(WB_STB_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O),
  .MAGNETIC_PICKUP_INPUT_I(MAGNETIC_PICKUP_INPUT_I),
  .ACTIVE_PICKUP_INPUT_I(ACTIVE_PICKUP_INPUT_I),
  .MAG_LINE_OK_I(MAG_LINE_OK_I), .SCALED_PULSE_O(SCALED_PULSE_O),
  .FREQUENCY_VALID_FLAG_O(FREQUENCY_VALID_FLAG_O),
  .WIRE_FAULT_O(WIRE_FAULT_O),
  .PICKUP_THRESHOLD_SELECT_O(PICKUP_THRESHOLD_SELECT_O), .IRQ_O(IRQ_O));

// [fip_pickup_model.sv]
// Speed pickup model: pulse trains on magnetic or active inputs
`timescale 1ns/1ps
module fip_pickup_model
  import fip_pkg::*;
(
  input  wire logic              clk_i,
  output logic      [NUM_CH-1:0] mag_o,
  output logic      [NUM_CH-1:0] act_o,
  output logic      [NUM_CH-1:0] line_ok_o
);
  // Idle pins rest low, lines start healthy
  initial begin
    mag_o = '0;
    act_o = '0;
    line_ok_o = '1;
  end
  // Only the chosen sensor of a channel toggles
  task automatic burst(input int ch, input bit act, input int hi,
                       input int lo, input int n);
    for (int i = 0; i < n; i++) begin
      if (act) act_o[ch] <= 1'b1;
      else mag_o[ch] <= 1'b1;
      repeat (hi) @(posedge clk_i);
      act_o[ch] <= 1'b0;
      mag_o[ch] <= 1'b0;
      repeat (lo) @(posedge clk_i);
    end
  endtask
  // Front end line status
  task automatic set_line(input int ch, input logic ok);
    line_ok_o[ch] <= ok;
  endtask
endmodule

// [fip_top_tb.sv]
// Self-checking bench for the frequency input pretreatment block
`timescale 1ns/1ps
module fip_top_tb;
  import fip_pkg::*;
  typedef struct {int ch; logic [31:0] cfg; int hi, lo, n, ex;} fip_row_t;
  logic              clk = 1'b0;
  logic              rst = 1'b1;
  logic              cyc = 1'b0;
  logic              stb = 1'b0;
  logic              we = 1'b0;
  logic [7:0]        adr = '0;
  logic [3:0]        sel = '0;
  logic [31:0]       wdat = '0;
  logic [31:0]       rdat, rd;
  logic              ack, irq;
  logic [NUM_CH-1:0] mag, act, lok, spul, valid, fault, thr;
  int                error_cnt = 0;
  int                n_checks = 0;
  int                pcnt [NUM_CH];
  // Channel, config, high, low, count, expected divided pulses
  fip_row_t rows [11] = '{
    '{0, 32'h0001_0004, 1, 3, 5, 5},
    '{0, 32'h0001_0005, 90, 90, 3, 3},
    '{0, 32'h0001_0005, 70, 90, 3, 0},
    '{1, 32'h0001_0002, 900, 900, 2, 2},
    '{1, 32'h0001_0002, 700, 900, 2, 0},
    '{1, 32'h0001_0003, 120, 120, 2, 2},
    '{1, 32'h0001_0003, 80, 120, 2, 0},
    '{0, 32'h0003_0005, 90, 90, 6, 2},
    '{0, 32'h0002_0005, 70, 90, 4, 0},
    '{0, 32'h0002_0005, 90, 90, 4, 2},
    '{0, 32'h0000_0005, 90, 90, 2, 2}};

  fip_top #(.HIGH_FILT_CYC(100)) DUT (.CLK_SYS_I(clk), .SYS_RST_I(rst),
    .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
    .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
    .MAGNETIC_PICKUP_INPUT_I(mag), .ACTIVE_PICKUP_INPUT_I(act),
    .MAG_LINE_OK_I(lok), .SCALED_PULSE_O(spul),
    .FREQUENCY_VALID_FLAG_O(valid), .WIRE_FAULT_O(fault),
    .PICKUP_THRESHOLD_SELECT_O(thr), .IRQ_O(irq));
  fip_pickup_model MDL (.clk_i(clk), .mag_o(mag), .act_o(act),
    .line_ok_o(lok));

  // Clock and divided pulse counters
  initial forever #25 clk = ~clk;
  always @(posedge clk) begin
    for (int c = 0; c < NUM_CH; c++) pcnt[c] += int'(spul[c]);
  end

  // Compare and report
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // One classic bus cycle; read data lands in rd
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, input logic [3:0] s);
    int i;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= s;
    // Wait for the rising edge at which ack is sampled high
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (ack === 1'b1) break;
    end
    if (i == 20) begin
      error_cnt++;
      $display("[ERR] %0t bus timeout", $time);
      tally_and_finish();
    end
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    // Reset values and an unmapped place
    wb(1'b0, FIP_CFG_OFS, '0, 4'hf);
    chk(rd, CFG_RST, "cfg reset");
    wb(1'b0, FIP_IMASK_OFS, '0, 4'hf);
    chk(rd, IMASK_RST, "mask reset");
    wb(1'b1, 8'h3c, 32'hffff_ffff, 4'hf);
    wb(1'b0, 8'h3c, '0, 4'hf);
    chk(rd, '0, "unmapped");
    // Table of filter and scaling cases
    foreach (rows[r]) begin
      wb(1'b1, 8'(4 * rows[r].ch), rows[r].cfg, 4'hf);
      pcnt[rows[r].ch] = 0;
      MDL.burst(rows[r].ch, rows[r].cfg[2], rows[r].hi, rows[r].lo,
                rows[r].n);
      repeat (4) @(posedge clk);
      chk(32'(pcnt[rows[r].ch]), 32'(rows[r].ex), "pulses");
    end
    // Byte lane write sets threshold select on channel 0
    wb(1'b1, FIP_CFG_OFS, 32'h0001_0004, 4'hf);
    wb(1'b1, FIP_CFG_OFS, 32'hffff_ff0b, 4'h1);
    wb(1'b0, FIP_CFG_OFS, '0, 4'hf);
    chk(rd, 32'h0001_000b, "lane write");
    chk(32'(thr), 32'h1, "threshold");
    // Broken line on channel 1, check on in sensitive mode
    wb(1'b1, FIP_CFG_OFS + FIP_CFG_STRIDE, 32'h0001_0011, 4'hf);
    MDL.set_line(1, 1'b0);
    repeat (8) @(posedge clk);
    chk(32'({fault, valid}), 32'h9, "broken wire");
    chk(32'(irq), 32'h0, "masked irq");
    wb(1'b1, FIP_IMASK_OFS, 32'h8, 4'hf);
    repeat (2) @(posedge clk);
    chk(32'(irq), 32'h1, "irq");
    wb(1'b1, FIP_ISTAT_OFS, 32'h8, 4'hf);
    repeat (2) @(posedge clk);
    chk(32'(irq), 32'h0, "irq clear");
    MDL.set_line(1, 1'b1);
    repeat (8) @(posedge clk);
    chk(32'({fault, valid}), 32'h3, "line back");
    // Divided pulse counters over all table rows
    wb(1'b0, FIP_PCNT_OFS, '0, 4'hf);
    chk(rd, 32'h0000_000e, "pcnt ch0");
    wb(1'b0, FIP_PCNT_OFS + FIP_CFG_STRIDE, '0, 4'hf);
    chk(rd, 32'h0000_0004, "pcnt ch1");
    // Status word: both valid, no fault, filtered levels low
    wb(1'b0, FIP_STAT_OFS, '0, 4'hf);
    chk(rd, 32'h0000_0300, "status");
    // Reset in mid-run restores the configuration defaults
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    wb(1'b0, FIP_CFG_OFS + FIP_CFG_STRIDE, '0, 4'hf);
    chk(rd, CFG_RST, "cfg after reset");
    chk(32'(thr), 32'h0, "threshold after reset");
    tally_and_finish();
  end
endmodule
